// [logic/crc_pkg.sv]
package crc_pkg;
   localparam int WORD_BITS = 72;
   localparam int CRC_BITS = 8;
   localparam int LANES = 8;
   localparam int X4_LANES = 4;
   localparam int BEAT_BITS = 8;
   localparam int TRANSFERS = 10;
   localparam int CRC_BEAT = 8;
   localparam int TAIL_BEAT = 9;
   localparam int X4_DATA_BITS = 32;
   localparam int INV_BASE = 64;
   localparam logic [CRC_BITS-1:0] CRC_POLY = 8'h07;
   localparam logic [CRC_BITS-1:0] CRC_INIT = 8'h00;
   localparam logic [3:0] BEAT_LAST = 4'h9;
   localparam logic [3:0] BEAT_LAST_NOCRC = 4'h7;
   localparam logic [3:0] BEAT_FIRST = 4'h0;
   localparam logic [2:0] ALERT_PULSE = 3'h6;

   typedef struct packed {
      logic inversion;
      logic [LANES-1:0] data;
   } transfer_t;

   typedef transfer_t [TRANSFERS-1:0] frame_t;

   typedef struct packed {
      logic [WORD_BITS-1:0] data;
      logic [CRC_BITS-1:0] checksum;
   } word_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CHECK = 2'h1,
      ST_ALERT = 2'h3
   } check_state_t;
endpackage

// [logic/crc8_tree.sv]
module crc8_tree (
   // Code word in
   input wire logic [crc_pkg::WORD_BITS-1:0] word,
   // Checksum out
   output logic [crc_pkg::CRC_BITS-1:0] checksum
);
   import crc_pkg::*;

   // Serial register unrolled; synthesis flattens it into XOR trees
   function automatic logic [CRC_BITS-1:0] checksum_next_fn(
         input logic [WORD_BITS-1:0] d);
      logic [CRC_BITS-1:0] c;
      logic fb;
      c = CRC_INIT;
      fb = 1'b0;
      for (int i = WORD_BITS - 1; i >= 0; i--) begin
         fb = c[CRC_BITS-1] ^ d[i];
         c = {c[CRC_BITS-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
      end
      return c;
   endfunction

   always_comb begin
      checksum = checksum_next_fn(word);
   end
endmodule

// [logic/write_data_crc8.sv]
module write_data_crc8 (
   // Device clock and reset
   input wire logic clk,
   input wire logic reset,
   // Write strobe domain
   input wire logic linkClk,
   input wire logic writeFrame,
   input wire logic [crc_pkg::LANES-1:0] dataLanes,
   input wire logic inversionLaneN,
   // Static configuration
   input wire logic crcEnable,
   input wire logic byFour,
   input wire logic inversionEnable,
   // Results
   output logic alertN,
   output logic wordValid,
   output crc_pkg::word_t word,
   output logic checkDone,
   output logic [crc_pkg::CRC_BITS-1:0] computedChecksum
);
   import crc_pkg::*;

   // ---------------- Link domain ----------------
   logic linkRstMeta, linkRst;
   logic crcEnLinkMeta, crcEnLink;
   logic [3:0] beat, next_beat;
   frame_t capture, next_capture;
   frame_t hold, next_hold;
   logic doneToggle, next_doneToggle;
   logic [3:0] lastBeat;

   always_ff @(posedge linkClk) begin
      linkRstMeta <= reset;
      linkRst <= linkRstMeta;
      crcEnLinkMeta <= crcEnable;
      crcEnLink <= crcEnLinkMeta;
   end

   // Frame length follows the checksum enable; a dropped frame signal
   // restarts the count so a short burst never merges with the next
   always_comb begin
      next_beat = beat;
      next_capture = capture;
      next_hold = hold;
      next_doneToggle = doneToggle;
      lastBeat = crcEnLink ? BEAT_LAST : BEAT_LAST_NOCRC;
      if (writeFrame) begin
         next_capture[beat] = {inversionLaneN, dataLanes};
         if (beat == lastBeat) begin
            next_beat = BEAT_FIRST;
            next_hold = next_capture;
            next_doneToggle = !doneToggle;
         end else begin
            next_beat = beat + 4'h1;
         end
      end else begin
         next_beat = BEAT_FIRST;
      end
   end

   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         beat <= BEAT_FIRST;
         capture <= '0;
         hold <= '0;
         doneToggle <= 1'b0;
      end else begin
         beat <= next_beat;
         capture <= next_capture;
         hold <= next_hold;
         doneToggle <= next_doneToggle;
      end
   end

   // ---------------- Device clock domain ----------------
   logic tglMeta, tglSync;
   logic [2:0] cfgMeta, cfgSync;
   logic cfgCrcEn, cfgByFour, cfgInvEn;
   logic tglSeen, next_tglSeen;
   logic pending;
   check_state_t state, next_state;
   logic [2:0] pulseCnt, next_pulseCnt;
   logic next_alertN, next_wordValid, next_checkDone;
   word_t next_word, mapped;
   logic [CRC_BITS-1:0] next_computed, treeOut;

   always_ff @(posedge clk) begin
      tglMeta <= doneToggle;
      tglSync <= tglMeta;
      cfgMeta <= {crcEnable, byFour, inversionEnable};
      cfgSync <= cfgMeta;
   end

   assign {cfgCrcEn, cfgByFour, cfgInvEn} = cfgSync;
   assign pending = tglSync ^ tglSeen;

   // Hold is stable for a whole frame after the toggle, so it is
   // safe to read here once the toggle has crossed
   always_comb begin
      mapped = '0;
      for (int l = 0; l < LANES; l++) begin
         for (int b = 0; b < BEAT_BITS; b++) begin
            mapped.data[l*BEAT_BITS+b] = hold[b].data[l];
         end
      end
      for (int b = 0; b < BEAT_BITS; b++) begin
         mapped.data[INV_BASE+b] = hold[b].inversion;
      end
      if (cfgByFour) begin
         mapped.data[WORD_BITS-1:X4_DATA_BITS] = '1;
         mapped.checksum = {hold[TAIL_BEAT].data[X4_LANES-1:0],
                            hold[CRC_BEAT].data[X4_LANES-1:0]};
      end else begin
         if (!cfgInvEn) begin
            mapped.data[WORD_BITS-1:INV_BASE] = '1;
         end
         mapped.checksum = hold[CRC_BEAT].data;
      end
   end

   crc8_tree u_tree (
      .word(word.data),
      .checksum(treeOut)
   );

   always_comb begin
      next_state = state;
      next_tglSeen = tglSeen;
      next_pulseCnt = pulseCnt;
      next_alertN = alertN;
      next_wordValid = 1'b0;
      next_checkDone = 1'b0;
      next_word = word;
      next_computed = computedChecksum;
      case (state)
         ST_IDLE: begin
            if (pending) begin
               next_tglSeen = tglSync;
               next_word = mapped;
               next_wordValid = 1'b1;
               if (cfgCrcEn) begin
                  next_state = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            next_checkDone = 1'b1;
            next_computed = treeOut;
            // Any nonzero syndrome alerts
            if (treeOut != word.checksum) begin
               next_alertN = 1'b0;
               next_pulseCnt = ALERT_PULSE - 3'h1;
               next_state = ST_ALERT;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_ALERT: begin
            if (pulseCnt == 3'h0) begin
               next_alertN = 1'b1;
               next_state = ST_IDLE;
            end else begin
               next_pulseCnt = pulseCnt - 3'h1;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_alertN = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= ST_IDLE;
         tglSeen <= 1'b0;
         pulseCnt <= 3'h0;
         alertN <= 1'b1;
         wordValid <= 1'b0;
         checkDone <= 1'b0;
         word <= '0;
         computedChecksum <= CRC_INIT;
      end else begin
         state <= next_state;
         tglSeen <= next_tglSeen;
         pulseCnt <= next_pulseCnt;
         alertN <= next_alertN;
         wordValid <= next_wordValid;
         checkDone <= next_checkDone;
         word <= next_word;
         computedChecksum <= next_computed;
      end
   end

   // ---------------- Checks ----------------
   property p_word_from_frame;
      @(posedge clk) disable iff (reset)
      wordValid |-> $past(pending) && $past(state == ST_IDLE);
   endproperty
   a_word_from_frame: assert property (p_word_from_frame)
      else $error("word delivered without a write frame");

   property p_no_check_disabled;
      @(posedge clk) disable iff (reset)
      wordValid && !cfgCrcEn |=> !checkDone && alertN;
   endproperty
   a_no_check_disabled: assert property (p_no_check_disabled)
      else $error("check ran with checksum disabled");

   property p_alert_on_mismatch;
      @(posedge clk) disable iff (reset)
      state == ST_CHECK && treeOut != word.checksum |=> !alertN && checkDone;
   endproperty
   a_alert_on_mismatch: assert property (p_alert_on_mismatch)
      else $error("mismatch did not raise alert");

   property p_quiet_on_match;
      @(posedge clk) disable iff (reset)
      state == ST_CHECK && treeOut == word.checksum |=> alertN [*2];
   endproperty
   a_quiet_on_match: assert property (p_quiet_on_match)
      else $error("alert raised on matching checksum");

   property p_alert_width;
      @(posedge clk) disable iff (reset)
      $fell(alertN) |-> (!alertN) [*6] ##1 alertN;
   endproperty
   a_alert_width: assert property (p_alert_width)
      else $error("alert pulse width is not six cycles");

   property p_x4_upper_ones;
      @(posedge clk) disable iff (reset)
      wordValid && cfgByFour |-> &word.data[WORD_BITS-1:X4_DATA_BITS];
   endproperty
   a_x4_upper_ones: assert property (p_x4_upper_ones)
      else $error("by-4 upper inputs not forced to one");

   property p_x8_noinv_ones;
      @(posedge clk) disable iff (reset)
      wordValid && !cfgByFour && !cfgInvEn |->
         &word.data[WORD_BITS-1:INV_BASE];
   endproperty
   a_x8_noinv_ones: assert property (p_x8_noinv_ones)
      else $error("inversion inputs not ones while disabled");

   property p_x4_checksum_map;
      @(posedge clk) disable iff (reset)
      wordValid && cfgByFour |-> word.checksum ==
         {hold[TAIL_BEAT].data[X4_LANES-1:0],
          hold[CRC_BEAT].data[X4_LANES-1:0]};
   endproperty
   a_x4_checksum_map: assert property (p_x4_checksum_map)
      else $error("by-4 checksum lanes misplaced");

   property p_x8_lane_map;
      @(posedge clk) disable iff (reset)
      wordValid && !cfgByFour |-> word.data[BEAT_BITS] == hold[0].data[1]
         && word.data[2*BEAT_BITS-1] == hold[7].data[1]
         && word.checksum == hold[CRC_BEAT].data;
   endproperty
   a_x8_lane_map: assert property (p_x8_lane_map)
      else $error("by-8 lane mapping wrong");

   property p_zero_word;
      @(posedge clk) disable iff (reset)
      state == ST_CHECK && word.data == '0 |=> computedChecksum == CRC_INIT;
   endproperty
   a_zero_word: assert property (p_zero_word)
      else $error("zero word gave nonzero checksum");

   property p_last_bit_poly;
      @(posedge clk) disable iff (reset)
      state == ST_CHECK && word.data == 72'h1 |=> computedChecksum == CRC_POLY;
   endproperty
   a_last_bit_poly: assert property (p_last_bit_poly)
      else $error("bit 0 did not enter last");

   property p_mismatch_seen;
      @(posedge clk) disable iff (reset)
      state == ST_CHECK && treeOut != word.checksum;
   endproperty
   c_mismatch_seen: cover property (p_mismatch_seen);

   property p_clean_x4;
      @(posedge clk) disable iff (reset)
      checkDone && alertN && cfgByFour;
   endproperty
   c_clean_x4: cover property (p_clean_x4);

   property p_disabled_word;
      @(posedge clk) disable iff (reset)
      wordValid && !cfgCrcEn;
   endproperty
   c_disabled_word: cover property (p_disabled_word);
endmodule

// [tb/link_ctrl_model.sv]
module link_ctrl_model (
   // Link outputs toward the device
   output logic linkClk,
   output logic writeFrame,
   output logic [crc_pkg::LANES-1:0] dataLanes,
   output logic inversionLaneN
);
   timeunit 1ns;
   timeprecision 1ns;
   import crc_pkg::*;

   initial begin
      linkClk = 1'b0;
      writeFrame = 1'b0;
      dataLanes = 8'h5a;
      inversionLaneN = 1'b1;
   end

   // Drive in the low phase, device captures on the rise
   task automatic beat(input logic fr, input transfer_t t);
      linkClk = 1'b0;
      writeFrame = fr;
      // Released lanes toggle so stale data is never mistaken for valid
      {inversionLaneN, dataLanes} = fr ? t : ~{inversionLaneN, dataLanes};
      #40 linkClk = 1'b1;
      #40;
   endtask

   // Only write bursts are ever sent; the link clock stops between calls
   task automatic send(input frame_t f, input int n, input int gap);
      #7;
      for (int b = 0; b < n; b++)
         beat(1'b1, f[b]);
      for (int b = 0; b < gap; b++)
         beat(1'b0, f[0]);
      linkClk = 1'b0;
   endtask
endmodule

// [tb/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import crc_pkg::*;

   logic clk, reset, crcEnable, byFour, inversionEnable;
   logic linkClk, writeFrame, inversionLaneN;
   logic alertN, wordValid, checkDone;
   logic [LANES-1:0] dataLanes;
   logic [CRC_BITS-1:0] computedChecksum;
   word_t word;
   int err_total = 0;
   int tests_run = 0;
   int wvCount = 0;
   int cdCount = 0;
   logic [31:0] seed = 32'h263d;

   write_data_crc8 dut_u (.clk(clk), .reset(reset), .linkClk(linkClk),
      .writeFrame(writeFrame), .dataLanes(dataLanes),
      .inversionLaneN(inversionLaneN), .crcEnable(crcEnable),
      .byFour(byFour), .inversionEnable(inversionEnable), .alertN(alertN),
      .wordValid(wordValid), .word(word), .checkDone(checkDone),
      .computedChecksum(computedChecksum));
   link_ctrl_model ctrl_u (.linkClk(linkClk), .writeFrame(writeFrame),
      .dataLanes(dataLanes), .inversionLaneN(inversionLaneN));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Counted on the falling edge, away from the launching edge, so each one-cycle pulse is seen once
   always @(negedge clk) begin
      if (wordValid === 1'b1) wvCount++;
      if (checkDone === 1'b1) cdCount++;
   end

   function automatic logic [71:0] rnd72();
      logic [71:0] r;
      r = '0;
      repeat (3) begin
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
         r = {r[47:0], seed[23:0]};
      end
      return r;
   endfunction

   // Serial reference: zero start, bit 71 shifted in first
   function automatic logic [7:0] crc_fn(input logic [71:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 71; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction

   function automatic logic [71:0] exw(input logic [71:0] d);
      if (byFour) d[71:32] = '1;
      else if (!inversionEnable) d[71:64] = '1;
      return d;
   endfunction

   function automatic frame_t mk(input logic [71:0] d, input logic [7:0] c);
      frame_t f;
      for (int b = 0; b < 8; b++) begin
         for (int n = 0; n < 8; n++)
            f[b].data[n] = d[8*n+b];
         f[b].inversion = d[64+b];
      end
      f[8] = {1'b1, byFour ? {4'hf, c[3:0]} : c};
      f[9] = {1'b1, byFour ? {4'hf, c[7:4]} : 8'hff};
      return f;
   endfunction

   task automatic chk_word(input logic [71:0] g, input logic [71:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic exp_frame(input logic [71:0] e, input logic [7:0] rx,
                            input logic bad);
      int k;
      int low;
      k = 0;
      low = 0;
      @(negedge clk);
      while (wordValid !== 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      chk_byte({7'h0, wordValid}, 8'h01);
      chk_word(word.data, e);
      if (crcEnable) begin
         chk_byte(word.checksum, rx);
         @(negedge clk);
         chk_byte({7'h0, checkDone}, 8'h01);
         chk_byte(computedChecksum, crc_fn(e));
         repeat (10) begin
            low += (alertN === 1'b0);
            @(negedge clk);
         end
         chk_byte(low[7:0], bad ? 8'(ALERT_PULSE) : 8'h00);
      end
   endtask

   task automatic run(input logic [71:0] d, input logic [7:0] c,
                      input logic [71:0] fl);
      fork
         ctrl_u.send(mk(d ^ fl, c), crcEnable ? 10 : 8, 2);
         exp_frame(exw(d ^ fl), c, fl != '0);
      join
   endtask

   task automatic setcfg(input logic en, input logic bf, input logic ie);
      @(negedge clk);
      crcEnable = en;
      byFour = bf;
      inversionEnable = ie;
      repeat (5) @(negedge clk);
   endtask

   task automatic conclude();
      $display("tests_run %0d err_total %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #400000;
      err_total++;
      conclude();
   end

   initial begin
      logic [71:0] d, d2, fl;
      int w, cd;
      reset = 1'b1;
      crcEnable = 1'b1;
      byFour = 1'b0;
      inversionEnable = 1'b1;
      fork
         repeat (2) @(negedge clk);
         ctrl_u.send(mk('0, '0), 0, 3);
      join
      @(negedge clk) reset = 1'b0;
      ctrl_u.send(mk('0, '0), 0, 3);
      run(72'h1, 8'h07, '0);
      chk_byte(computedChecksum, 8'h07);
      run('0, 8'h00, '0);
      chk_byte(computedChecksum, 8'h00);
      $display("test known vector done");
      // Each mode against clean, single, double and column errors
      for (int i = 0; i < 32; i++) begin
         setcfg(1'b1, i[0], i[1]);
         d = rnd72();
         case (i[3:2])
            2'h0: fl = '0;
            2'h1: fl = 72'h1 << d[4:0];
            2'h2: fl = (72'h1 << d[4:0]) | (72'h200 << d[3:0]);
            default: fl = 72'h01010101 << d[2:0];
         endcase
         run(d, crc_fn(exw(d)), fl);
      end
      $display("test random modes done");
      setcfg(1'b0, 1'b0, 1'b1);
      cd = cdCount;
      run(d, 8'h00, '0);
      repeat (3) @(negedge clk);
      chk_byte(8'(cdCount - cd), 8'h00);
      chk_byte({7'h0, alertN}, 8'h01);
      $display("test checksum disabled done");
      setcfg(1'b1, 1'b0, 1'b0);
      w = wvCount;
      ctrl_u.send(mk(d, 8'h00), 6, 2);
      repeat (6) @(negedge clk);
      chk_byte(8'(wvCount - w), 8'h00);
      run(d, crc_fn(exw(d)), '0);
      $display("test aborted frame done");
      d2 = rnd72();
      fork
         begin
            ctrl_u.send(mk(d, crc_fn(exw(d))), 10, 0);
            ctrl_u.send(mk(d2, crc_fn(exw(d2))), 10, 2);
         end
         begin
            exp_frame(exw(d), crc_fn(exw(d)), 1'b0);
            exp_frame(exw(d2), crc_fn(exw(d2)), 1'b0);
         end
      join
      $display("test back to back done");
      conclude();
   end
endmodule
